// ===== hdl/incr_exec.sv
// Overview of operation
// [RL1] Read operand byte, produce value plus one.
// [RL2] Target bit picks accumulator or operand byte.
// [RL3] Plain increment opcode is 001010 prefix.
// [RL4] Plain increment updates all five arithmetic flags.
// [RL5] Window bit picks bank pointer or fast bank.
// [RL6] Extended set indexes operands up to 95.
// [RL7] Decode, read, process, write over four quarters.
// [RL8] Skip variant keeps flags, skips on zero.
// [RL9] Skip variant opcode is 001111 prefix.
// [RL10] Increment wraps modulo 256 for skip test.
// [RL11] Skipped slot writes nothing, updates no flags.
`timescale 1ns/1ps
`default_nettype none

module incr_exec (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        instr_valid,
  input  wire logic [15:0] instr_word,
  input  wire logic        next_is_two_word,
  input  wire logic        ext_set_enable,
  input  wire logic [3:0]  bank_pointer_reg,
  input  wire logic [11:0] index_base,
  input  wire logic [7:0]  mem_rdata,
  output logic [11:0]      mem_addr,
  output logic             mem_re,
  output logic [7:0]       mem_wdata,
  output logic             mem_we,
  output logic [7:0]       primary_result_register,
  output logic [4:0]       status_flags,
  output logic             skip_flush
);

  typedef struct packed {
    incr_pkg::op_e op;
    logic          dest;
    logic [11:0]   addr;
    logic          re;
    logic [7:0]    operand;
    logic [7:0]    result;
    logic [4:0]    new_flags;
    logic [7:0]    wdata;
    logic          we;
    logic [7:0]    w;
    logic [4:0]    flags;
    logic [1:0]    skip_cnt;
    logic          flush;
  } exec_s;

  exec_s   st_reg;
  exec_s   st_next;
  phase_if ph ();

  quarter_phase u_phase (
    .clock (clock),
    .rst   (rst),
    .ph    (ph)
  );

  // ************************************************************
  // Helper functions
  // ************************************************************

  // Forms the 12-bit operand address from window bit and index.
  function automatic logic [11:0] operand_address(input logic win, input logic [7:0] idx,
                                                  input logic ext, input logic [3:0] bank,
                                                  input logic [11:0] base);
    logic [11:0] a;
    a = {bank, idx};                                               // [RL5]
    if (!win) begin
      if (ext && idx <= incr_pkg::INDEXED_LIMIT) begin
        a = base + {4'h0, idx};                                    // [RL6]
      end else if (idx <= incr_pkg::INDEXED_LIMIT) begin
        a = {incr_pkg::FAST_LOW_BANK, idx};                        // [RL5]
      end else begin
        a = {incr_pkg::FAST_HIGH_BANK, idx};                       // [RL5]
      end
    end
    return a;
  endfunction

  // Builds the flag vector for an increment of the given operand.
  function automatic logic [4:0] inc_flags(input logic [7:0] v);
    logic [8:0] sum;
    logic [4:0] f;
    sum                       = {1'b0, v} + 9'h001;
    f                         = 5'h00;
    f[incr_pkg::FLAG_CARRY]   = sum[8];                            // [RL4]
    f[incr_pkg::FLAG_NIBBLE]  = (v[3:0] == 4'hF);                  // [RL4]
    f[incr_pkg::FLAG_ZERO]    = (sum[7:0] == 8'h00);               // [RL4]
    f[incr_pkg::FLAG_WRAP]    = (v == 8'h7F);                      // [RL4]
    f[incr_pkg::FLAG_MSB]     = sum[7];                            // [RL4]
    return f;
  endfunction

  // ************************************************************
  // Execution sequencer
  // ************************************************************

  // Advances decode, read, process and write on the four quarters.
  always_comb begin
    st_next = st_reg;
    case (ph.phase)
      incr_pkg::PH_DECODE: begin
        st_next.op = incr_pkg::OP_NONE;
        if (instr_valid && !st_reg.flush) begin                    // [RL11]
          if (instr_word[incr_pkg::OPC_MSB:incr_pkg::OPC_LSB] == incr_pkg::INC_OPCODE) begin
            st_next.op = incr_pkg::OP_INC;                         // [RL3]
          end else if (instr_word[incr_pkg::OPC_MSB:incr_pkg::OPC_LSB] == incr_pkg::SKZ_OPCODE) begin
            st_next.op = incr_pkg::OP_SKZ;                         // [RL9]
          end
          st_next.dest = instr_word[incr_pkg::DEST_BIT];
          st_next.addr = operand_address(instr_word[incr_pkg::WIN_BIT], instr_word[7:0],
                                         ext_set_enable, bank_pointer_reg, index_base);
          st_next.re   = (st_next.op != incr_pkg::OP_NONE);        // [RL7]
        end
      end
      incr_pkg::PH_READ: begin
        st_next.re      = 1'b0;
        st_next.operand = mem_rdata;                               // [RL1]
      end
      incr_pkg::PH_PROCESS: begin
        if (st_reg.op != incr_pkg::OP_NONE) begin
          st_next.result    = st_reg.operand + 8'h01;              // [RL1] [RL10]
          st_next.new_flags = inc_flags(st_reg.operand);
          st_next.wdata     = st_reg.operand + 8'h01;
          st_next.we        = st_reg.dest;                         // [RL2]
        end
      end
      incr_pkg::PH_WRITE: begin
        st_next.we = 1'b0;
        if (st_reg.op != incr_pkg::OP_NONE) begin
          if (!st_reg.dest) begin
            st_next.w = st_reg.result;                             // [RL2]
          end
          if (st_reg.op == incr_pkg::OP_INC) begin
            st_next.flags = st_reg.new_flags;                      // [RL4]
          end else if (st_reg.result == 8'h00) begin
            st_next.skip_cnt = next_is_two_word ? incr_pkg::SKIP_TWO : incr_pkg::SKIP_ONE; // [RL8]
            st_next.flush    = 1'b1;
          end
        end else if (st_reg.skip_cnt != 2'h0) begin
          st_next.skip_cnt = st_reg.skip_cnt - 2'h1;               // [RL8]
          st_next.flush    = (st_reg.skip_cnt != incr_pkg::SKIP_ONE);
        end
      end
      default: begin
        st_next = st_reg;
      end
    endcase
  end

  // Registers the whole executor state.
  always_ff @(posedge clock) begin
    if (rst) begin
      st_reg.op        <= incr_pkg::OP_NONE;
      st_reg.dest      <= 1'b0;
      st_reg.addr      <= incr_pkg::ADDR_RESET;
      st_reg.re        <= 1'b0;
      st_reg.operand   <= incr_pkg::RESULT_RESET;
      st_reg.result    <= incr_pkg::RESULT_RESET;
      st_reg.new_flags <= incr_pkg::FLAGS_RESET;
      st_reg.wdata     <= incr_pkg::RESULT_RESET;
      st_reg.we        <= 1'b0;
      st_reg.w         <= incr_pkg::RESULT_RESET;
      st_reg.flags     <= incr_pkg::FLAGS_RESET;
      st_reg.skip_cnt  <= 2'h0;
      st_reg.flush     <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs come straight from the state flip-flops.
  assign mem_addr                = st_reg.addr;
  assign mem_re                  = st_reg.re;
  assign mem_wdata               = st_reg.wdata;
  assign mem_we                  = st_reg.we;
  assign primary_result_register = st_reg.w;
  assign status_flags            = st_reg.flags;
  assign skip_flush              = st_reg.flush;

  // ************************************************************
  // Checks
  // ************************************************************

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  // An accepted plain increment in the decode quarter.
  sequence seq_take_inc;
    ph.phase == incr_pkg::PH_DECODE && instr_valid && !skip_flush &&
    instr_word[15:10] == incr_pkg::INC_OPCODE;
  endsequence

  // The write quarter of an executing instruction.
  sequence seq_write_q;
    ph.phase == incr_pkg::PH_WRITE && st_reg.op != incr_pkg::OP_NONE;
  endsequence

  // The byte read two quarters before the write strobe plus one must be written back.
  AST_WDATA_PLUS_ONE: assert property ($rose(mem_we) |-> mem_wdata == $past(mem_rdata, 2) + 8'h01) // [RL1]
    else $error("Written byte is not operand plus one.");
  AST_MEM_DEST: assert property (seq_take_inc ##0 instr_word[9] |-> ##3 mem_we ##1 !mem_we) // [RL2]
    else $error("Memory target not written in write quarter.");
  AST_W_DEST: assert property (seq_write_q ##0 !st_reg.dest |=> primary_result_register == $past(st_reg.result)) // [RL2]
    else $error("Accumulator not loaded with result.");
  AST_DECODE_INC: assert property (seq_take_inc |=> st_reg.op == incr_pkg::OP_INC && mem_re) // [RL3]
    else $error("Plain increment not decoded.");
  AST_FLAG_ZERO: assert property (seq_take_inc ##1 (mem_rdata == 8'hFF) |-> ##3
                                  status_flags[2] && status_flags[0]) // [RL4]
    else $error("Zero and carry not set after wrap.");
  AST_BANK_ADDR: assert property (seq_take_inc ##0 instr_word[8] |=>
                                  mem_addr == {$past(bank_pointer_reg), $past(instr_word[7:0])}) // [RL5]
    else $error("Bank pointer address wrong.");
  AST_INDEXED: assert property (seq_take_inc ##0 !instr_word[8] && ext_set_enable &&
                                instr_word[7:0] <= 8'h5F |=>
                                mem_addr == $past(index_base) + {4'h0, $past(instr_word[7:0])}) // [RL6]
    else $error("Indexed operand address wrong.");
  AST_READ_QUARTER: assert property (mem_re |-> ph.phase == incr_pkg::PH_READ) // [RL7]
    else $error("Operand read outside read quarter.");
  AST_SKZ_FLAGS: assert property (seq_write_q ##0 st_reg.op == incr_pkg::OP_SKZ |=> $stable(status_flags)) // [RL8]
    else $error("Skip variant changed flags.");
  AST_SKIP_ON_ZERO: assert property (seq_write_q ##0 st_reg.op == incr_pkg::OP_SKZ && st_reg.result == 8'h00
                                     |=> skip_flush [*4]) // [RL8] [RL10]
    else $error("Zero result did not start skip.");
  AST_SKIP_IDLE: assert property (skip_flush && ph.phase == incr_pkg::PH_DECODE |=> !mem_re [*4]) // [RL11]
    else $error("Skipped slot did work.");

endmodule

`default_nettype wire

// ===== inc/incr_pkg.sv
package incr_pkg;

  // ************************************************************
  // Instruction layout
  // ************************************************************
  localparam logic [5:0]  INC_OPCODE      = 6'h0A;
  localparam logic [5:0]  SKZ_OPCODE      = 6'h0F;
  localparam int          OPC_MSB         = 15;
  localparam int          OPC_LSB         = 10;
  localparam int          DEST_BIT        = 9;
  localparam int          WIN_BIT         = 8;

  // ************************************************************
  // Operand addressing
  // ************************************************************
  localparam logic [7:0]  INDEXED_LIMIT   = 8'h5F;
  localparam logic [3:0]  FAST_LOW_BANK   = 4'h0;
  localparam logic [3:0]  FAST_HIGH_BANK  = 4'hF;

  // ************************************************************
  // Quarter phases and reset values
  // ************************************************************
  localparam logic [1:0]  PH_DECODE       = 2'h0;
  localparam logic [1:0]  PH_READ         = 2'h1;
  localparam logic [1:0]  PH_PROCESS      = 2'h2;
  localparam logic [1:0]  PH_WRITE        = 2'h3;
  localparam logic [7:0]  RESULT_RESET    = 8'h00;
  localparam logic [11:0] ADDR_RESET      = 12'h000;
  localparam logic [1:0]  SKIP_ONE        = 2'h1;
  localparam logic [1:0]  SKIP_TWO        = 2'h2;

  // ************************************************************
  // Flag vector positions
  // ************************************************************
  localparam int          FLAG_CARRY      = 0;
  localparam int          FLAG_NIBBLE     = 1;
  localparam int          FLAG_ZERO       = 2;
  localparam int          FLAG_WRAP       = 3;
  localparam int          FLAG_MSB        = 4;
  localparam logic [4:0]  FLAGS_RESET     = 5'h00;

  typedef enum logic [1:0] {
    OP_NONE = 2'b00,
    OP_INC  = 2'b01,
    OP_SKZ  = 2'b10
  } op_e;

endpackage

// ===== inc/phase_if.sv
`timescale 1ns/1ps
`default_nettype none

// Quarter phase of the instruction cycle shared between the sequencer and the executor.
interface phase_if;
  logic [1:0] phase;
  modport src (output phase);
  modport dst (input phase);
endinterface

`default_nettype wire

// ===== hdl/quarter_phase.sv
`timescale 1ns/1ps
`default_nettype none

module quarter_phase (
  input  wire logic clock,
  input  wire logic rst,
  phase_if.src      ph
);

  typedef struct packed {
    logic [1:0] phase;
  } seq_s;

  seq_s st_reg;
  seq_s st_next;

  // ************************************************************
  // Phase counter
  // ************************************************************

  // Steps through the four quarters, wrapping from the write phase.
  always_comb begin
    st_next       = st_reg;
    st_next.phase = st_reg.phase + 2'h1;
  end

  // Registers the phase, restarting at decode.
  always_ff @(posedge clock) begin
    if (rst) begin
      st_reg.phase <= incr_pkg::PH_DECODE;
    end else begin
      st_reg <= st_next;
    end
  end

  // Publishes the registered phase.
  assign ph.phase = st_reg.phase;

endmodule

`default_nettype wire

// ===== verif/data_mem_model.sv
`timescale 1ns/1ps
`default_nettype none

// Behavioural data memory on the far side of the operand port.
module data_mem_model (
  input  wire logic        clock,
  input  wire logic [11:0] mem_addr,
  input  wire logic        mem_re,
  input  wire logic [7:0]  mem_wdata,
  input  wire logic        mem_we,
  output logic [7:0]       mem_rdata
);
  logic [7:0] mem [0:4095];
  logic [7:0] last_reg = 8'h3C;

  // Writes land at the edge; the last byte read is remembered.
  always @(posedge clock) begin
    if (mem_we)
      mem[mem_addr] <= mem_wdata;
    if (mem_re)
      last_reg <= mem[mem_addr];
  end

  // Outside a read the bus shows the inverse of the last byte, so stale data is never trusted.
  assign mem_rdata = mem_re ? mem[mem_addr] : ~last_reg;
endmodule

`default_nettype wire

// ===== verif/register_increment_exec_test.sv
`timescale 1ns/1ps
`default_nettype none

module register_increment_exec_test;
  logic        clock, rst, instr_valid, next_is_two_word, ext_set_enable, mem_re, mem_we, skip_flush;
  logic [15:0] instr_word;
  logic [3:0]  bank_pointer_reg;
  logic [11:0] index_base, mem_addr;
  logic [7:0]  mem_rdata, mem_wdata, primary_result_register;
  logic [4:0]  status_flags;
  logic [31:0] seed = 32'h49141CA8;
  int          mismatches = 0, n_tests = 0, cycles = 0, exp_acc = 0, exp_flags = 0;
  int          exp_mem [4096];

  incr_exec uut (.clock(clock), .rst(rst), .instr_valid(instr_valid), .instr_word(instr_word),
    .next_is_two_word(next_is_two_word), .ext_set_enable(ext_set_enable), .bank_pointer_reg(bank_pointer_reg),
    .index_base(index_base), .mem_rdata(mem_rdata), .mem_addr(mem_addr), .mem_re(mem_re), .mem_wdata(mem_wdata),
    .mem_we(mem_we), .primary_result_register(primary_result_register), .status_flags(status_flags),
    .skip_flush(skip_flush));
  data_mem_model mdl (.clock(clock), .mem_addr(mem_addr), .mem_re(mem_re), .mem_wdata(mem_wdata),
    .mem_we(mem_we), .mem_rdata(mem_rdata));

  // Clock generation and a cycle ceiling that cuts a hang short.
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles++;
    if (cycles > 20000) begin
      mismatches++;
      close_out();
    end
  end

  // Helpers: random source, comparison and verdict.
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input logic ok, input string msg);
    n_tests++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Reference operand address from the window bit, the bank and the extended mode.
  function automatic int addr_of(input logic [15:0] w, input logic [31:0] r);
    int idx = w[7:0];
    if (w[8]) return r[3:0] * 256 + idx;
    if (r[4] && idx <= 95) return (r[16:5] + idx) % 4096;
    return (idx <= 95) ? idx : 3840 + idx;
  endfunction

  // Drives one instruction word and its level inputs at a rising edge.
  task automatic drive(input logic [15:0] w, input logic [31:0] r);
    instr_valid <= (r[31:28] != 4'h0);
    instr_word <= w;
    bank_pointer_reg <= r[3:0];
    ext_set_enable <= r[4];
    index_base <= r[16:5];
    next_is_two_word <= r[17];
  endtask

  task automatic check_state(input logic flush);
    chk(primary_result_register === exp_acc[7:0], "accumulator");
    chk(status_flags === exp_flags[4:0], "status flags");
    chk(skip_flush === flush, "flush level");
  endtask

  // A discarded slot: a valid word is offered but nothing may happen.
  task automatic slot();
    for (int k = 0; k < 4; k++) begin
      @(posedge clock);
      if (k == 0)
        instr_word <= {incr_pkg::INC_OPCODE, seed[9:0]};
      #1;
      chk(skip_flush === 1'b1 && mem_re === 1'b0 && mem_we === 1'b0, "skipped slot");
    end
  endtask

  // Read, process and write quarters; then the model is updated.
  task automatic rest(input logic [15:0] w, input logic [31:0] r);
    int a;
    logic [7:0] v, res;
    logic ok;
    ok = ((w[15:10] == incr_pkg::INC_OPCODE) || (w[15:10] == incr_pkg::SKZ_OPCODE)) && (r[31:28] != 4'h0);
    a = addr_of(w, r);
    v = exp_mem[a][7:0];
    res = v + 8'h01;
    chk(mem_re === ok, "read strobe in read quarter");
    if (ok) chk(mem_addr === a[11:0], "operand address");
    @(posedge clock);
    #1;
    chk(mem_re === 1'b0, "read strobe length");
    @(posedge clock);
    #1;
    chk(mem_we === (ok & w[9]), "write strobe");
    if (ok && w[9]) chk(mem_wdata === res, "write data");
    if (ok && w[9]) exp_mem[a] = res;
    if (ok && !w[9]) exp_acc = res;
    if (ok && w[15:10] == incr_pkg::INC_OPCODE)
      exp_flags = {res[7], v == 8'h7F, res == 8'h00, v[3:0] == 4'hF, v == 8'hFF};
    if (ok && w[15:10] == incr_pkg::SKZ_OPCODE && res == 8'h00)
      repeat (r[17] ? 2 : 1) slot();
  endtask

  // One full instruction; a swapped opcode is offered outside the decode quarter.
  task automatic do_instr(input logic [15:0] w);
    logic [31:0] r;
    r = xs();
    @(posedge clock);
    drive(w, r);
    #1;
    check_state(1'b0);
    @(posedge clock);
    instr_word <= {w[15:10] ^ 6'h05, w[9:0]};
    #1;
    rest(w, r);
  endtask

  // Main sequence: reset, phase alignment, then random instructions.
  initial begin
    logic [31:0] r;
    logic [15:0] w;
    logic [5:0]  op;
    rst = 1'b1;
    {instr_valid, next_is_two_word, ext_set_enable, bank_pointer_reg, index_base, instr_word} = '0;
    for (int i = 0; i < 4096; i++) begin
      r = xs();
      exp_mem[i] = (r[1:0] == 2'h0) ? 8'hFF : (r[1:0] == 2'h1) ? 8'h7F : (r[1:0] == 2'h2) ? 8'h0F : r[15:8];
      mdl.mem[i] = exp_mem[i][7:0];
    end
    repeat (8) @(posedge clock);
    #1;
    check_state(1'b0);
    chk(mem_re === 1'b0 && mem_we === 1'b0, "strobes in reset");
    r = xs() | 32'h10000000;
    w = {incr_pkg::INC_OPCODE, 2'b00, 8'h34};
    @(posedge clock);
    rst <= 1'b0;
    drive(w, r);
    for (int k = 0; k < 8 && mem_re !== 1'b1; k++) begin
      @(posedge clock);
      #1;
    end
    rest(w, r);
    repeat (300) begin
      r = xs();
      op = (r[1:0] == 2'h1) ? incr_pkg::SKZ_OPCODE : incr_pkg::INC_OPCODE;
      if (r[1:0] == 2'h3)
        op = (r[15:10] == incr_pkg::INC_OPCODE || r[15:10] == incr_pkg::SKZ_OPCODE) ? 6'h3E : r[15:10];
      do_instr({op, r[25:16]});
    end
    do_instr(16'hFFFF);
    close_out();
  end
endmodule

`default_nettype wire
